/* shared/fws_cfg.svh */
// Purpose: constants for the flash write-status poller
// Assumes: 200 MHz clk, APB register access
// Notes:   one aligned 32-bit word per register
`ifndef FWS_CFG_SVH
`define FWS_CFG_SVH
`define FWS_REG_CTRL     12'h000
`define FWS_REG_ADDR     12'h004
`define FWS_REG_STATUS   12'h008
`define FWS_REG_RESULT   12'h00C
`define FWS_REG_IRQ_STAT 12'h010
`define FWS_REG_IRQ_EN   12'h014
`define FWS_REG_IRQ_CLR  12'h018
`define FWS_REG_CMD_DATA 12'h01C
// Control bits
`define FWS_CTRL_POLL    0
`define FWS_CTRL_RESET   1
`define FWS_CTRL_WRITE   2
`define FWS_CTRL_TIMER   3
// Status bits of the completion poll
`define FWS_BIT_POLLING  7
`define FWS_BIT_TOGGLE   6
`define FWS_BIT_LIMIT    5
`define FWS_BIT_TIMER    3
// Flash reset command byte and its address
`define FWS_RESET_DATA   8'hF0
`define FWS_RESET_ADDR   16'h0000
// Read and write cycle times
`define FWS_CYCLE_NS     100
`define FWS_CLK_NS       5
`define FWS_CYCLE_CLKS   ((`FWS_CYCLE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
// Interrupt event bits
`define FWS_EV_DONE      0
`define FWS_EV_FAIL      1
`define FWS_EV_TIMER     2
`define FWS_EV_BUSYREL   3
`endif

/* shared/fws_pkg.sv */
// Purpose: types for the flash write-status poller
// Assumes: nothing beyond the constants header
// Notes:   results are encoded in the result register
package fws_pkg;
  typedef enum logic [1:0] {
    FWS_RES_NONE,
    FWS_RES_OK,
    FWS_RES_FAIL,
    FWS_RES_BUSY
  } fws_result_type;
  typedef enum logic [1:0] {
    FWS_CYC_READ,
    FWS_CYC_WRITE
  } fws_cycle_type;
endpackage

/* design/fws_bus_cycle.sv */
// Purpose: one timed read or write cycle on the flash parallel bus
// Assumes: cycle length covers access time of the slowest grade
// Notes:   data bus is three signals: in, out and active-low enable
`include "fws_cfg.svh"
module fws_bus_cycle (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Request
  input  wire logic                   start,
  input  wire fws_pkg::fws_cycle_type kind,
  input  wire logic [15:0]            addr,
  input  wire logic [7:0]             wrData,
  output logic                        done,
  output logic [7:0]                  rdData,
  // Flash pins
  output logic [15:0]                 flashAddr,
  output logic                        flashCeN,
  output logic                        flashOeN,
  output logic                        flashWeN,
  output logic [7:0]                  flashDqOut,
  output logic                        flashDqOeN,
  input  wire logic [7:0]             flashDqIn
);
  logic [7:0] cnt_q;
  logic       act_q;
  logic       wr_q;

  // Cycle timer; strobes drop for the whole count, sample at the end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      act_q <= 1'b0;
      wr_q  <= 1'b0;
    end else if (!act_q && start) begin
      act_q <= 1'b1;
      wr_q  <= (kind == fws_pkg::FWS_CYC_WRITE);
      cnt_q <= 8'(`FWS_CYCLE_CLKS);
    end else if (act_q) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01) act_q <= 1'b0;
    end
  end

  // Pins from flops so no glitch reaches the flash
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flashAddr  <= 16'h0000;
      flashCeN   <= 1'b1;
      flashOeN   <= 1'b1;
      flashWeN   <= 1'b1;
      flashDqOut <= 8'h00;
      flashDqOeN <= 1'b1;
    end else if (!act_q && start) begin
      flashAddr  <= addr;
      flashCeN   <= 1'b0;
      flashOeN   <= (kind == fws_pkg::FWS_CYC_WRITE);
      flashWeN   <= (kind != fws_pkg::FWS_CYC_WRITE);
      flashDqOut <= wrData;
      flashDqOeN <= (kind != fws_pkg::FWS_CYC_WRITE);
    end else if (act_q && cnt_q == 8'h01) begin
      flashCeN   <= 1'b1;
      flashOeN   <= 1'b1;
      flashWeN   <= 1'b1;
      flashDqOeN <= 1'b1;
    end
  end

  // Read data latched while output enable still low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= 8'h00;
      done   <= 1'b0;
    end else begin
      done <= act_q && cnt_q == 8'h01;
      if (act_q && cnt_q == 8'h01 && !wr_q) rdData <= flashDqIn;
    end
  end
endmodule // fws_bus_cycle

/* design/fws_poller.sv */
// Purpose: host-side write-status poller for a parallel flash
// Assumes: APB slave, flash pins driven by fws_bus_cycle
// Notes:   software starts the program or erase sequence itself via
//          the raw write control; this block judges completion
//
// Behaviour
// - Detection always starts with two back-to-back reads whose toggle bits are compared.
// - If still toggling with the limit flag high, recheck; stopped is success, else fail and reset.
// - Toggling with limit low allows polling on or quitting, and a restart begins with two reads.
// - After a limit failure the host writes the reset command to return to array reads.
// - The timer bit may be skipped only if extra sector erases come under 50 us apart.
// - Host checks timer bit before and after each extra sector erase; high after means refused.
//
// Added by the designer: register access over APB and the address map.
`include "fws_cfg.svh"
module fws_poller (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Flash pins
  output logic [15:0]      flashAddr,
  output logic             flashCeN,
  output logic             flashOeN,
  output logic             flashWeN,
  output logic [7:0]       flashDqOut,
  output logic             flashDqOeN,
  input  wire logic [7:0]  flashDqIn,
  input  wire logic        readyBusyN
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ1,
    ST_READ2,
    ST_RECHK,
    ST_RESET,
    ST_WRITE,
    ST_TIMER
  } fws_state_type;

  fws_state_type         state_q;
  logic [15:0]           addr_q;
  logic [7:0]            cmdData_q;
  logic [7:0]            first_q;
  logic [7:0]            last_q;
  fws_pkg::fws_result_type result_q;
  logic                  limitSeen_q;
  logic                  timerBit_q;
  logic [3:0]            irqStat_q;
  logic [3:0]            irqEn_q;
  logic                  rdy_q;
  logic                  rdyPrev_q;

  // Bus cycle engine handshake
  logic                  cycStart;
  fws_pkg::fws_cycle_type cycKind;
  logic [15:0]           cycAddr;
  logic [7:0]            cycWrData;
  logic                  cycDone;
  logic [7:0]            cycRdData;

  logic                  apbWr;
  logic [3:0]            events;
  logic                  ctrlWr;
  logic                  busy;

  // Toggle comparison between two sampled bytes
  function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
    toggled = a[`FWS_BIT_TOGGLE] ^ b[`FWS_BIT_TOGGLE];
  endfunction

  // Register writes take effect on the access edge; slave is zero-wait
  assign apbWr   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign ctrlWr  = apbWr && paddr == `FWS_REG_CTRL;
  assign busy    = state_q != ST_IDLE;
  assign pslverr = 1'b0;

  // Command parameters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q    <= 16'h0000;
      cmdData_q <= 8'h00;
    end else if (apbWr && !busy) begin
      if (paddr == `FWS_REG_ADDR) addr_q <= pwdata[15:0];
      if (paddr == `FWS_REG_CMD_DATA) cmdData_q <= pwdata[7:0];
    end
  end

  // Sequencer; control writes while busy are ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      first_q     <= 8'h00;
      last_q      <= 8'h00;
      result_q    <= fws_pkg::FWS_RES_NONE;
      limitSeen_q <= 1'b0;
      timerBit_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (ctrlWr && pwdata[`FWS_CTRL_POLL]) begin
            state_q  <= ST_READ1;
            result_q <= fws_pkg::FWS_RES_NONE;
          end else if (ctrlWr && pwdata[`FWS_CTRL_RESET]) begin
            state_q <= ST_RESET;
          end else if (ctrlWr && pwdata[`FWS_CTRL_WRITE]) begin
            state_q <= ST_WRITE;
          end else if (ctrlWr && pwdata[`FWS_CTRL_TIMER]) begin
            state_q <= ST_TIMER;
          end
        end
        ST_READ1: if (cycDone) begin
          first_q <= cycRdData;
          state_q <= ST_READ2;
        end
        ST_READ2: if (cycDone) begin
          last_q <= cycRdData;
          if (!toggled(first_q, cycRdData)) begin
            result_q <= fws_pkg::FWS_RES_OK;
            state_q  <= ST_IDLE;
          end else if (cycRdData[`FWS_BIT_LIMIT]) begin
            limitSeen_q <= 1'b1;
            first_q     <= cycRdData;
            state_q     <= ST_RECHK;
          end else begin
            result_q <= fws_pkg::FWS_RES_BUSY;
            state_q  <= ST_IDLE;
          end
        end
        ST_RECHK: if (cycDone) begin
          last_q <= cycRdData;
          if (!toggled(first_q, cycRdData)) begin
            result_q <= fws_pkg::FWS_RES_OK;
            state_q  <= ST_IDLE;
          end else begin
            result_q <= fws_pkg::FWS_RES_FAIL;
            state_q  <= ST_RESET;
          end
        end
        ST_RESET: if (cycDone) state_q <= ST_IDLE;
        ST_WRITE: if (cycDone) state_q <= ST_IDLE;
        ST_TIMER: if (cycDone) begin
          timerBit_q <= cycRdData[`FWS_BIT_TIMER];
          last_q     <= cycRdData;
          state_q    <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // One cycle request per state entry: start while engine idle
  logic issued_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) issued_q <= 1'b0;
    else if (cycDone || state_q == ST_IDLE) issued_q <= 1'b0;
    else issued_q <= 1'b1;
  end

  // Cycle kind and data per state
  always_comb begin
    cycStart  = busy && !issued_q;
    cycKind   = fws_pkg::FWS_CYC_READ;
    cycAddr   = addr_q;
    cycWrData = cmdData_q;
    if (state_q == ST_RESET) begin
      cycKind   = fws_pkg::FWS_CYC_WRITE;
      cycAddr   = `FWS_RESET_ADDR;
      cycWrData = `FWS_RESET_DATA;
    end else if (state_q == ST_WRITE) begin
      cycKind = fws_pkg::FWS_CYC_WRITE;
    end
  end

  fws_bus_cycle u_cycle (
    .clk        (clk),
    .rst        (rst),
    .start      (cycStart),
    .kind       (cycKind),
    .addr       (cycAddr),
    .wrData     (cycWrData),
    .done       (cycDone),
    .rdData     (cycRdData),
    .flashAddr  (flashAddr),
    .flashCeN   (flashCeN),
    .flashOeN   (flashOeN),
    .flashWeN   (flashWeN),
    .flashDqOut (flashDqOut),
    .flashDqOeN (flashDqOeN),
    .flashDqIn  (flashDqIn)
  );

  // Ready/busy pin is open drain, pulled up; watch for release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdy_q     <= 1'b1;
      rdyPrev_q <= 1'b1;
    end else begin
      rdy_q     <= readyBusyN;
      rdyPrev_q <= rdy_q;
    end
  end

  // Events: done ok, failure, window closed, busy released
  // Only a compared pair counts; the first read has no partner yet
  assign events[`FWS_EV_DONE]    = (state_q == ST_READ2 || state_q == ST_RECHK) && cycDone
                                   && !toggled(first_q, cycRdData);
  assign events[`FWS_EV_FAIL]    = state_q == ST_RECHK && cycDone
                                   && toggled(first_q, cycRdData);
  assign events[`FWS_EV_TIMER]   = state_q == ST_TIMER && cycDone
                                   && cycRdData[`FWS_BIT_TIMER];
  assign events[`FWS_EV_BUSYREL] = rdy_q && !rdyPrev_q;

  // Sticky status; set beats clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) irqStat_q <= 4'h0;
    else irqStat_q <= (irqStat_q & ~((apbWr && paddr == `FWS_REG_IRQ_CLR) ?
                       pwdata[3:0] : 4'h0)) | events;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) irqEn_q <= 4'h0;
    else if (apbWr && paddr == `FWS_REG_IRQ_EN) irqEn_q <= pwdata[3:0];
  end

  assign irq = |(irqStat_q & irqEn_q);

  // Read mux; unmapped and write-only read as zero
  always_comb begin
    case (paddr)
      `FWS_REG_CTRL:     prdata = 32'h0000_0000;
      `FWS_REG_ADDR:     prdata = {16'h0000, addr_q};
      `FWS_REG_STATUS:   prdata = {16'h0000, last_q, 4'h0, busy, ~rdy_q,
                                   limitSeen_q, timerBit_q};
      `FWS_REG_RESULT:   prdata = {30'h0000_0000, result_q};
      `FWS_REG_IRQ_STAT: prdata = {28'h000_0000, irqStat_q};
      `FWS_REG_IRQ_EN:   prdata = {28'h000_0000, irqEn_q};
      `FWS_REG_CMD_DATA: prdata = {24'h00_0000, cmdData_q};
      default:           prdata = 32'h0000_0000;
    endcase
  end
endmodule // fws_poller

/* tb/fws_flash_model.sv */
// Purpose: behavioural flash answering status reads
// Assumes: strobes seen on the bench clock
// Notes:   idle data bus shows the inverse of its last value
module fws_flash_model (
  // Bench control
  input  wire logic       clk,
  input  wire logic       opStart,
  input  wire logic [7:0] opReads,
  input  wire logic       opFail,
  input  wire logic       opErase,
  // Flash pins
  input  wire logic       flashCeN,
  input  wire logic       flashOeN,
  input  wire logic       flashWeN,
  input  wire logic [7:0] flashDqOut,
  output logic [7:0]      dqIn,
  output logic            readyBusyN,
  output logic [7:0]      resets
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ArrayByte = 8'h5A;
  logic       busy = 1'b0;
  logic       tog = 1'b0;
  logic       limit = 1'b0;
  logic       prevOe = 1'b1;
  logic       prevWe = 1'b1;
  logic [7:0] left = 8'h00;
  logic [7:0] lastOut = 8'h00;
  logic [7:0] resetCnt = 8'h00;
  logic [7:0] status;
  // Status byte of a running algorithm
  assign status = {opErase ? 1'b0 : ~ArrayByte[7], tog, limit, 1'b0, opErase, 3'h0};
  // Unselected bus never repeats a stale byte
  assign dqIn = (!flashCeN && !flashOeN) ? (busy ? status : ArrayByte) : ~lastOut;
  assign readyBusyN = !busy;
  assign resets = resetCnt;
  // Each finished read advances the algorithm
  always @(posedge clk) begin
    prevOe <= flashOeN;
    prevWe <= flashWeN;
    if (!flashOeN) lastOut <= dqIn;
    if (opStart) begin
      busy <= 1'b1;
      left <= opReads;
      limit <= 1'b0;
    end else if (!prevOe && flashOeN && busy) begin
      tog <= ~tog;
      if (left != 8'h00) left <= left - 8'h01;
      else if (opFail) limit <= 1'b1;
      else busy <= 1'b0;
    end
    // Reset command ends a program; a running erase ignores it
    if (!prevWe && flashWeN && flashDqOut == 8'hF0 && !(busy && opErase)) begin
      busy <= 1'b0;
      limit <= 1'b0;
      resetCnt <= resetCnt + 8'h01;
    end
  end
endmodule // fws_flash_model

/* tb/fws_poller_chk.sv */
// Purpose: port checks for the status poller
// Assumes: one clock, hand-over timing
// Notes:   bound to fws_poller
`include "fws_cfg.svh"
module fws_poller_chk (
  // Clock, reset
  input wire logic        clk,
  input wire logic        rst,
  // APB and interrupt
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  // Flash strobes
  input wire logic [15:0] flashAddr,
  input wire logic        flashCeN,
  input wire logic        flashOeN,
  input wire logic        flashWeN,
  input wire logic        flashDqOeN
);
  timeunit 1ns;
  timeprecision 1ps;
  int oeCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Read strobe low time; short means an early sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) oeCnt <= 0;
    else if (flashOeN) oeCnt <= 0;
    else oeCnt <= oeCnt + 1;
  end
  property p_rd; !flashOeN |-> !flashCeN && flashWeN && flashDqOeN; endproperty
  a_rd: assert property (p_rd) else $error("bad read strobes");
  property p_wr; !flashWeN |-> !flashCeN && flashOeN && !flashDqOeN; endproperty
  a_wr: assert property (p_wr) else $error("bad write strobes");
  property p_oelen; $rose(flashOeN) |-> oeCnt == `FWS_CYCLE_CLKS; endproperty
  a_oelen: assert property (p_oelen) else $error("read length wrong");
  property p_gap; $rose(flashCeN) |-> flashCeN [*2]; endproperty
  a_gap: assert property (p_gap) else $error("cycle gap short");
  property p_rel; $rose(flashCeN) |-> flashOeN && flashWeN; endproperty
  a_rel: assert property (p_rel) else $error("strobe left low");
  property p_addr; !flashCeN && !$past(flashCeN) |-> $stable(flashAddr); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_dq; $rose(flashWeN) |=> flashDqOeN; endproperty
  a_dq: assert property (p_dq) else $error("data bus held");
  property p_rdy; psel && penable |-> pready && !pslverr; endproperty
  a_rdy: assert property (p_rdy) else $error("apb answer wrong");
  c_rd: cover property ($rose(flashOeN));
  c_wr: cover property ($rose(flashWeN));
  c_irq: cover property ($rose(irq));
endmodule // fws_poller_chk
bind fws_poller fws_poller_chk u_chk (.clk, .rst, .psel, .penable, .pready, .pslverr,
  .irq, .flashAddr, .flashCeN, .flashOeN, .flashWeN, .flashDqOeN);

/* tb/fws_poller_tb_top.sv */
// Purpose: scenario bench for the status poller
// Assumes: flash model on the far side
// Notes:   one read or write per APB call
`include "fws_cfg.svh"
module fws_poller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, s;
  logic [15:0] flashAddr;
  logic        flashCeN, flashOeN, flashWeN, flashDqOeN, readyBusyN;
  logic [7:0]  flashDqOut, flashDqIn, resets, opReads;
  logic        opStart, opFail, opErase;
  int          fails, compares;
  fws_poller u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .flashAddr, .flashCeN, .flashOeN, .flashWeN, .flashDqOut,
    .flashDqOeN, .flashDqIn, .readyBusyN);
  fws_flash_model u_mem (.clk, .opStart, .opReads, .opFail, .opErase, .flashCeN,
    .flashOeN, .flashWeN, .flashDqOut, .dqIn(flashDqIn), .readyBusyN, .resets);
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // APB transfer, held until pready at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      fails++;
      complete_run;
    end
    s = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a); apb(1'b0, a, 32'h0000_0000); endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  // Bounded wait for the sequencer
  task automatic idle;
    for (int n = 0; n < 300; n++) begin
      rd(`FWS_REG_STATUS);
      if (s[3] === 1'b0) return;
    end
    fails++;
    complete_run;
  endtask
  task automatic poll; wr(`FWS_REG_CTRL, 32'h0000_0001); idle; rd(`FWS_REG_RESULT); endtask
  task automatic op(input logic [7:0] n, input logic f, input logic e);
    @(posedge clk);
    opReads <= n;
    opFail <= f;
    opErase <= e;
    opStart <= 1'b1;
    @(posedge clk);
    opStart <= 1'b0;
  endtask
  // Reset values, unmapped place
  task automatic t_reset;
    rd(`FWS_REG_STATUS);
    chk(s, 4'h0);
    rd(`FWS_REG_IRQ_STAT);
    chk(s, 4'h0);
    wr(12'h020, 32'hFFFF_FFFF);
    rd(12'h020);
    chk(s, 4'h0);
    chk({flashCeN, flashOeN, flashWeN, flashDqOeN}, 4'hF);
  endtask
  // Idle flash: done event, mask, clear
  task automatic t_idle;
    poll;
    chk(s, 4'h1);
    @(negedge clk);
    chk(irq, 1'h0);
    wr(`FWS_REG_IRQ_EN, 32'h0000_0001);
    @(negedge clk);
    chk(irq, 1'h1);
    wr(`FWS_REG_IRQ_CLR, 32'h0000_0001);
    @(negedge clk);
    chk(irq, 1'h0);
  endtask
  // Toggling with limit low, then finishes
  task automatic t_busy;
    op(8'h03, 1'b0, 1'b0);
    poll;
    chk(s, 4'h3);
    for (int k = 0; k < 8 && s == 3; k++) poll;
    chk(s, 4'h1);
    chk(resets, 4'h0);
  endtask
  // Limit reached while toggling
  task automatic t_fail;
    op(8'h02, 1'b1, 1'b0);
    s = 3;
    for (int k = 0; k < 8 && s == 3; k++) poll;
    chk(s, 4'h2);
    chk(resets, 4'h1);
    chk(readyBusyN, 1'h1);
    rd(`FWS_REG_IRQ_STAT);
    chk(s[1], 1'h1);
    rd(`FWS_REG_STATUS);
    chk(s[1], 1'h1);
  endtask
  // Erase timer bit, busy pin, reset command
  task automatic t_timer;
    op(8'h04, 1'b0, 1'b1);
    rd(`FWS_REG_STATUS);
    chk(s[2], 1'h1);
    wr(`FWS_REG_IRQ_CLR, 32'h0000_0008);
    rd(`FWS_REG_IRQ_STAT);
    chk(s[3], 1'h0);
    wr(`FWS_REG_CTRL, 32'h0000_0008);
    idle;
    chk(s[0], 1'h1);
    rd(`FWS_REG_IRQ_STAT);
    chk(s[2], 1'h1);
    wr(`FWS_REG_CTRL, 32'h0000_0002);
    idle;
    chk(resets, 8'h01);
    chk(readyBusyN, 1'h0);
    s = 3;
    for (int k = 0; k < 8 && s == 3; k++) poll;
    chk(s, 4'h1);
    rd(`FWS_REG_IRQ_STAT);
    chk(s[3], 1'h1);
  endtask
  // Raw command write through the address and data registers
  task automatic t_raw;
    wr(`FWS_REG_ADDR, 32'h0000_1234);
    wr(`FWS_REG_CMD_DATA, 32'h0000_00F0);
    rd(`FWS_REG_ADDR);
    chk(s, 32'h0000_1234);
    wr(`FWS_REG_CTRL, 32'h0000_0004);
    idle;
    chk(flashAddr, 16'h1234);
    chk(resets, 8'h02);
  endtask
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Main sequence
  initial begin
    {rst, psel, penable, pwrite, opStart, opFail, opErase} = 7'h40;
    {paddr, pwdata, opReads} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_idle;
    t_busy;
    t_fail;
    t_timer;
    t_raw;
    complete_run;
  end
endmodule // fws_poller_tb_top
